/* File: include/ccsr_pkg.sv */
`default_nettype none
package ccsr_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_STATUS  = 8'h03;
    localparam logic [7:0] ADDR_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_VTIMING = 8'h05;

    // Reset values
    localparam logic [7:0] RST_STATUS  = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'hb1;
    localparam logic [7:0] RST_VTIMING = 8'h80;

    // Status bit positions
    localparam int ST_HOT_DIE   = 7;
    localparam int ST_INLIM     = 6;
    localparam int ST_TPAUSE    = 5;
    localparam int ST_END_CUR   = 4;
    localparam int ST_ACTIVE    = 3;
    localparam int ST_TMR_EXP   = 2;
    localparam int ST_PRE_EXP   = 1;
    localparam int ST_THERM_F   = 0;

    // Control bit positions
    localparam int CT_TIMER_HI  = 7;
    localparam int CT_TIMER_LO  = 6;
    localparam int CT_TMR_ON    = 5;
    localparam int CT_CURVE     = 4;
    localparam int CT_RESTART   = 3;
    localparam int CT_NO_TERM   = 2;
    localparam int CT_HOLD      = 1;
    localparam int CT_CHG_ON    = 0;

    // Voltage and timing bit positions
    localparam int VT_SLOW      = 7;
    localparam int VT_PRETH     = 6;
    localparam int VT_VSEL_HI   = 5;
    localparam int VT_VSEL_LO   = 4;
    localparam int VT_RSV_HI    = 3;

    // Fast-charge timer durations in hours, by code
    localparam logic [3:0] TMR_HOURS_00 = 4'h4;
    localparam logic [3:0] TMR_HOURS_01 = 4'h5;
    localparam logic [3:0] TMR_HOURS_10 = 4'h6;
    localparam logic [3:0] TMR_HOURS_11 = 4'h8;

    // Target voltage in millivolts, by code
    localparam logic [12:0] VTARGET_00_MV = 13'd4100;
    localparam logic [12:0] VTARGET_01_MV = 13'd4150;
    localparam logic [12:0] VTARGET_1X_MV = 13'd4200;

    // Precharge thresholds in millivolts
    localparam logic [12:0] VPRE_LOW_SEL0_MV = 13'd2900;
    localparam logic [12:0] VPRE_LOW_SEL1_MV = 13'd2500;

    // Thermistor beta values
    localparam logic [11:0] BETA_100K = 12'd3960;
    localparam logic [11:0] BETA_10K  = 12'd3480;

endpackage : ccsr_pkg
`default_nettype wire

/* File: logic/ccsr_regs.sv */
// What this block does
// - Status bit 7 shows die-heat current cut
// - Status bit 6 shows input-limit loop active
// - Status bit 5 shows battery temperature pause
// - Status bit 4 shows termination current reached
// - Status bit 3 shows charger actively charging
// - Status bit 2 shows any timer expired
// - Status bit 1 shows precharge timer expired
// - Status bit 0 shows thermistor fault
// - Control bits 7:6 pick fast-charge timer hours
// - Control bit 5 runs both safety timers
// - Control bit 4 picks thermistor curve
// - Control bit 2 suppresses current termination
// - Control bit 1 freezes safety timers
// - Control bit 0 enables the charger
// - Config bit 7 halves timer rate in loops
// - Config bit 6 picks precharge threshold
// - Config bits 5:4 pick target voltage
// - Config bits 3:0 are plain storage
`timescale 1ns/1ns
`default_nettype none

module ccsr_regs
(
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output var  logic [7:0]  reg_rdata,
    input  wire logic        hot_die_current_cut,
    input  wire logic        input_limit_loop_active,
    input  wire logic        battery_temp_pause,
    input  wire logic        end_current_reached,
    input  wire logic        charging_active,
    input  wire logic        charge_timer_expired,
    input  wire logic        precharge_timer_expired,
    input  wire logic        thermistor_fault,
    output var  logic [3:0]  fast_timer_hours,
    output var  logic        safety_timers_on,
    output var  logic        thermistor_curve_select,
    output var  logic [11:0] thermistor_beta,
    output var  logic        charger_restart,
    output var  logic        current_term_enable,
    output var  logic        hold_safety_timers,
    output var  logic        safety_timers_run,
    output var  logic        charger_on,
    output var  logic        timer_slowdown_select,
    output var  logic        timer_half_rate,
    output var  logic        precharge_threshold_select,
    output var  logic [12:0] precharge_threshold_mv,
    output var  logic [1:0]  target_voltage_select,
    output var  logic [12:0] target_voltage_mv
);

    logic [7:0]  status_q;
    logic [7:0]  status_d;
    logic [7:0]  control_q;
    logic [7:0]  vtiming_q;
    logic [7:0]  rdata_d;
    logic        wr_control;
    logic        wr_vtiming;
    logic [3:0]  hours_d;
    logic [12:0] vtarget_d;
    logic [12:0] vpre_d;
    logic [11:0] beta_d;

    // Address decode; no strobe exists for the status register
    // status writes dropped
    assign wr_control = reg_wr && (reg_addr == ccsr_pkg::ADDR_CONTROL);
    assign wr_vtiming = reg_wr && (reg_addr == ccsr_pkg::ADDR_VTIMING);

    // Live charger state gathered into the status byte
    // hot die flag
    assign status_d[ccsr_pkg::ST_HOT_DIE] = hot_die_current_cut;
    assign status_d[ccsr_pkg::ST_INLIM]   = input_limit_loop_active;
    assign status_d[ccsr_pkg::ST_TPAUSE]  = battery_temp_pause;
    assign status_d[ccsr_pkg::ST_END_CUR] = end_current_reached;
    assign status_d[ccsr_pkg::ST_ACTIVE]  = charging_active;
    // any timer flag, includes precharge expiry
    assign status_d[ccsr_pkg::ST_TMR_EXP] = charge_timer_expired | precharge_timer_expired;
    assign status_d[ccsr_pkg::ST_PRE_EXP] = precharge_timer_expired;
    assign status_d[ccsr_pkg::ST_THERM_F] = thermistor_fault;

    // Read data mux; unmapped addresses read zero
    assign rdata_d = !reg_rd                             ? 8'h00 :
                     (reg_addr == ccsr_pkg::ADDR_STATUS)  ? status_q :
                     (reg_addr == ccsr_pkg::ADDR_CONTROL) ? control_q :
                     (reg_addr == ccsr_pkg::ADDR_VTIMING) ? vtiming_q : 8'h00;

    assign hours_d =
        (control_q[ccsr_pkg::CT_TIMER_HI:ccsr_pkg::CT_TIMER_LO] == 2'b00) ? ccsr_pkg::TMR_HOURS_00 :
        (control_q[ccsr_pkg::CT_TIMER_HI:ccsr_pkg::CT_TIMER_LO] == 2'b01) ? ccsr_pkg::TMR_HOURS_01 :
        (control_q[ccsr_pkg::CT_TIMER_HI:ccsr_pkg::CT_TIMER_LO] == 2'b10) ? ccsr_pkg::TMR_HOURS_10 :
                                                                            ccsr_pkg::TMR_HOURS_11;

    assign beta_d = control_q[ccsr_pkg::CT_CURVE] ? ccsr_pkg::BETA_10K : ccsr_pkg::BETA_100K;

    assign vpre_d = vtiming_q[ccsr_pkg::VT_PRETH] ? ccsr_pkg::VPRE_LOW_SEL1_MV
                                                  : ccsr_pkg::VPRE_LOW_SEL0_MV;

    // target voltage decode, both upper codes give the top value
    assign vtarget_d =
        vtiming_q[ccsr_pkg::VT_VSEL_HI] ? ccsr_pkg::VTARGET_1X_MV :
        vtiming_q[ccsr_pkg::VT_VSEL_LO] ? ccsr_pkg::VTARGET_01_MV :
                                          ccsr_pkg::VTARGET_00_MV;

    // Status snapshot register
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            status_q <= ccsr_pkg::RST_STATUS;
        else
            status_q <= status_d;
    end

    // Control register; restart bit held until host clears it
    // restart stays while bit is set
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            control_q <= ccsr_pkg::RST_CONTROL;
        else if (wr_control)
            control_q <= reg_wdata;
    end

    // Voltage and timing register, reserved low nibble kept as storage
    // reserved bits stored
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            vtiming_q <= ccsr_pkg::RST_VTIMING;
        else if (wr_vtiming)
            vtiming_q <= reg_wdata;
    end

    // Registered read data
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= rdata_d;
    end

    // Registered controls toward the charger core
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fast_timer_hours           <= ccsr_pkg::TMR_HOURS_10;
            safety_timers_on           <= 1'b1;
            thermistor_curve_select    <= 1'b1;
            thermistor_beta            <= ccsr_pkg::BETA_10K;
            charger_restart            <= 1'b0;
            current_term_enable        <= 1'b1;
            hold_safety_timers         <= 1'b0;
            safety_timers_run          <= 1'b0;
            charger_on                 <= 1'b1;
            timer_slowdown_select      <= 1'b1;
            timer_half_rate            <= 1'b0;
            precharge_threshold_select <= 1'b0;
            precharge_threshold_mv     <= ccsr_pkg::VPRE_LOW_SEL0_MV;
            target_voltage_select      <= 2'b00;
            target_voltage_mv          <= ccsr_pkg::VTARGET_00_MV;
        end
        else
        begin
            fast_timer_hours           <= hours_d;
            safety_timers_on           <= control_q[ccsr_pkg::CT_TMR_ON];
            thermistor_curve_select    <= control_q[ccsr_pkg::CT_CURVE];
            thermistor_beta            <= beta_d;
            charger_restart            <= control_q[ccsr_pkg::CT_RESTART];
            current_term_enable        <= !control_q[ccsr_pkg::CT_NO_TERM];
            hold_safety_timers         <= control_q[ccsr_pkg::CT_HOLD];
            // timers count only when on, not frozen and not restarting
            safety_timers_run          <= control_q[ccsr_pkg::CT_TMR_ON]
                                          && !control_q[ccsr_pkg::CT_HOLD]
                                          && !control_q[ccsr_pkg::CT_RESTART];
            charger_on                 <= control_q[ccsr_pkg::CT_CHG_ON];
            timer_slowdown_select      <= vtiming_q[ccsr_pkg::VT_SLOW];
            // half rate in thermal or input-limit loop
            timer_half_rate            <= vtiming_q[ccsr_pkg::VT_SLOW]
                                          && (hot_die_current_cut || input_limit_loop_active);
            precharge_threshold_select <= vtiming_q[ccsr_pkg::VT_PRETH];
            precharge_threshold_mv     <= vpre_d;
            target_voltage_select      <= vtiming_q[ccsr_pkg::VT_VSEL_HI:ccsr_pkg::VT_VSEL_LO];
            target_voltage_mv          <= vtarget_d;
        end
    end

endmodule // ccsr_regs

`default_nettype wire

/* File: verification/ccsr_regs_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module ccsr_regs_chk
(
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        hot_die_current_cut,
    input wire logic        input_limit_loop_active,
    input wire logic        battery_temp_pause,
    input wire logic        end_current_reached,
    input wire logic        charging_active,
    input wire logic        charge_timer_expired,
    input wire logic        precharge_timer_expired,
    input wire logic        thermistor_fault,
    input wire logic        safety_timers_on,
    input wire logic        thermistor_curve_select,
    input wire logic        charger_restart,
    input wire logic        current_term_enable,
    input wire logic        hold_safety_timers,
    input wire logic        safety_timers_run,
    input wire logic        charger_on,
    input wire logic        timer_slowdown_select,
    input wire logic        timer_half_rate,
    input wire logic [3:0]  fast_timer_hours,
    input wire logic [11:0] thermistor_beta,
    input wire logic [12:0] precharge_threshold_mv,
    input wire logic [12:0] target_voltage_mv
);
    // Write strobes and expected status byte
    wire       w_ctl = reg_wr && reg_addr == 8'h04;
    wire       w_vt  = reg_wr && reg_addr == 8'h05;
    wire [7:0] st_exp = {hot_die_current_cut, input_limit_loop_active, battery_temp_pause,
        end_current_reached, charging_active, charge_timer_expired | precharge_timer_expired,
        precharge_timer_expired, thermistor_fault};
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    a_status_read: assert property (reg_rd && reg_addr == 8'h03
        |=> reg_rdata == $past(st_exp, 2)) else $error("status byte wrong");
    a_timer_hours: assert property (w_ctl |=> ##1 fast_timer_hours ==
        ($past(reg_wdata[7:6], 2) == 2'h3 ? 4'h8 : 4'h4 + {2'h0, $past(reg_wdata[7:6], 2)}))
        else $error("timer hours wrong");
    a_timer_curve: assert property (w_ctl |=> ##1 safety_timers_on == $past(reg_wdata[5], 2)
        && thermistor_beta == ($past(reg_wdata[4], 2) ? 12'd3480 : 12'd3960))
        else $error("timer enable or curve wrong");
    a_term_hold_on: assert property (w_ctl |=> ##1 current_term_enable == !$past(reg_wdata[2], 2)
        && hold_safety_timers == $past(reg_wdata[1], 2) && charger_on == $past(reg_wdata[0], 2))
        else $error("term, hold or enable wrong");
    a_run_gate: assert property ($past(reset_n) |-> safety_timers_run ==
        (safety_timers_on && !hold_safety_timers && !charger_restart)) else $error("run gate wrong");
    a_half_rate: assert property ($past(reset_n) |-> timer_half_rate ==
        (timer_slowdown_select && $past(hot_die_current_cut || input_limit_loop_active)))
        else $error("half rate wrong");
    a_pre_volt: assert property (w_vt |=> ##1 precharge_threshold_mv ==
        ($past(reg_wdata[6], 2) ? 13'd2500 : 13'd2900)) else $error("precharge level wrong");
    a_target_volt: assert property (w_vt |=> ##1 target_voltage_mv ==
        ($past(reg_wdata[5], 2) ? 13'd4200 : $past(reg_wdata[4], 2) ? 13'd4150 : 13'd4100))
        else $error("target voltage wrong");
    // Main scenarios reached
    c_status: cover property (reg_rd && reg_addr == 8'h03);
    c_ctl: cover property (w_ctl);
    c_half: cover property (timer_half_rate);
endmodule // ccsr_regs_chk
bind ccsr_regs ccsr_regs_chk u_ccsr_regs_chk (.*);
`default_nettype wire

/* File: verification/ccsr_host.sv */
`timescale 1ns/1ns
`default_nettype none
module ccsr_host (
    input  wire logic       core_clk,
    output var  logic [7:0] reg_addr,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    // Idle bus at time zero
    initial
    begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
    end
    // One write strobe; data scrambled after release
    task automatic wr(input logic [7:0] a, input logic [7:0] dv);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= dv;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~dv;
    endtask
    // One read strobe; data taken the cycle after
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        q = reg_rdata;
    endtask
endmodule // ccsr_host
`default_nettype wire

/* File: verification/charger_config_status_regs_test.sv */
`timescale 1ns/1ns
`default_nettype none
module charger_config_status_regs_test;
    logic        core_clk, reset_n, reg_wr, reg_rd, safety_timers_on, thermistor_curve_select;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, st, d, v;
    logic        hot_die_current_cut, input_limit_loop_active, battery_temp_pause;
    logic        end_current_reached, charging_active, charge_timer_expired;
    logic        precharge_timer_expired, thermistor_fault, charger_restart, current_term_enable;
    logic        hold_safety_timers, safety_timers_run, charger_on, timer_slowdown_select;
    logic        timer_half_rate, precharge_threshold_select;
    logic [1:0]  target_voltage_select;
    logic [3:0]  fast_timer_hours;
    logic [11:0] thermistor_beta;
    logic [12:0] precharge_threshold_mv, target_voltage_mv;
    int          n_fail, check_count, seed, i;
    // Behavioural register model, keyed by address
    int          mdl [int];
    // Charger core status levels
    assign {hot_die_current_cut, input_limit_loop_active, battery_temp_pause, end_current_reached,
        charging_active, charge_timer_expired, precharge_timer_expired, thermistor_fault} = st;
    ccsr_regs u_ccsr_regs (.*);
    ccsr_host u_ccsr_host (.*);
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        u_ccsr_host.rd(a, q);
        chk({8'h00, q}, {8'h00, e});
    endtask
    // Write through the host and mirror it in the model
    task automatic wr_m(input logic [7:0] a, input logic [7:0] dv);
        u_ccsr_host.wr(a, dv);
        if (a == 8'h04 || a == 8'h05)
            mdl[a] = dv;
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard, far beyond the under 150 cycles used
    initial
    begin
        #200000;
        n_fail++;
        report_and_stop;
    end
    initial
    begin
        seed = 71503;
        n_fail = 0;
        check_count = 0;
        st = 8'h00;
        mdl[4] = 8'hb1;
        mdl[5] = 8'h80;
        reset_n = 1'b0;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        chk_rd(8'h03, 8'h00);
        chk_rd(8'h04, 8'hb1);
        chk_rd(8'h05, 8'h80);
        chk(fast_timer_hours, 4'h6);
        chk(thermistor_beta, 12'd3480);
        // One-hot then random status, with ignored writes
        for (i = 0; i < 16; i++)
        begin
            @(posedge core_clk);
            st <= (i < 8) ? 8'h01 << i : 8'($random(seed));
            u_ccsr_host.wr(8'h03, 8'($random(seed)));
            v = {st[7:3], st[2] | st[1], st[1:0]};
            chk_rd(8'h03, v);
        end
        // Every timer code with random control bits
        for (i = 0; i < 4; i++)
        begin
            d = {i[1:0], 6'($random(seed))};
            wr_m(8'h04, d);
            chk_rd(8'h04, d);
            chk(thermistor_curve_select, d[4]);
            chk(fast_timer_hours, (i == 3) ? 4'h8 : 4'h4 + 4'(i));
            chk({safety_timers_on, current_term_enable, hold_safety_timers, charger_on},
                {d[5], !d[2], d[1], d[0]});
            chk(thermistor_beta, d[4] ? 12'd3480 : 12'd3960);
        end
        // Restart set, then cleared by the host
        wr_m(8'h04, 8'h29);
        chk_rd(8'h04, 8'h29);
        chk({charger_restart, safety_timers_run}, 16'h0002);
        wr_m(8'h04, 8'h21);
        chk_rd(8'h04, 8'h21);
        chk({charger_restart, safety_timers_run}, 16'h0001);
        // Every voltage code with random other bits
        for (i = 0; i < 4; i++)
        begin
            d = {2'($random(seed)), i[1:0], 4'($random(seed))};
            st <= 8'(i << 6);
            wr_m(8'h05, d);
            chk_rd(8'h05, d);
            chk(target_voltage_mv, d[5] ? 13'd4200 : d[4] ? 13'd4150 : 13'd4100);
            chk(precharge_threshold_mv, d[6] ? 13'd2500 : 13'd2900);
            chk(timer_half_rate, d[7] & (st[7] | st[6]));
            chk(timer_slowdown_select, d[7]);
            chk(precharge_threshold_select, d[6]);
            chk(target_voltage_select, d[5:4]);
        end
        // Unmapped place reads zero, leaves others alone
        u_ccsr_host.wr(8'h07, 8'hff);
        chk_rd(8'h07, 8'h00);
        chk_rd(8'h04, 8'h21);
        chk_rd(8'h04, 8'(mdl[4]));
        chk_rd(8'h05, 8'(mdl[5]));
        report_and_stop;
    end
endmodule // charger_config_status_regs_test
`default_nettype wire
